// File: rtl/pdc3_pkg.sv
// Package for the peripheral disable control register 3 block.
// Assumes a single 250 MHz clock domain and a plain register port.
package pdc3_pkg;
   localparam int PDC3_ADDR_W = 4;
   localparam logic [3:0] PDC3_OFF_CTRL = 4'h0;
   localparam logic [15:0] PDC3_CTRL_RESET = 16'h0000;
   localparam logic [15:0] PDC3_CTRL_MASK = 16'hF003;
   localparam int PDC3_BIT_T9 = 15;
   localparam int PDC3_BIT_T8 = 14;
   localparam int PDC3_BIT_T7 = 13;
   localparam int PDC3_BIT_T6 = 12;
   localparam int PDC3_BIT_TW2 = 1;
   localparam int PDC3_BIT_AD2 = 0;
   localparam int PDC3_NPINS = 16;

   typedef struct packed {
      logic timer_nine_off;
      logic timer_eight_off;
      logic timer_seven_off;
      logic timer_six_off;
      logic second_twowire_off;
      logic second_converter_off;
   } pdc3_off_t;
endpackage

// File: rtl/pdc3_pin_mode.sv
// Per-pin analog or digital mode for pins shared with the converters.
// Assumes the configuration vectors come from registers in the same domain.
`timescale 1ns/1ps
`default_nettype none
module pdc3_pin_mode
   import pdc3_pkg::*;
#(
   parameter int NPINS = PDC3_NPINS
) (
   input wire logic [NPINS-1:0] cfg1_i,
   input wire logic [NPINS-1:0] cfg2_i,
   input wire logic conv2_off_i,
   output logic [NPINS-1:0] analog_o
);
   genvar g;
   generate
      for (g = 0; g < NPINS; g++) begin : g_pin
         // A cleared bit in either enabled converter selects analog
         assign analog_o[g] = ~cfg1_i[g] | (~cfg2_i[g] & ~conv2_off_i);
      end
   endgenerate
endmodule
`default_nettype wire

// File: rtl/pdc3_ctrl.sv
// Peripheral disable control register 3 with its per-module disables.
// Assumes a single-cycle register port with read data one cycle later.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Bit 14 set disables the eighth timer, clear keeps it enabled.
// - Bit 12 set disables the sixth timer, clear keeps it enabled.
// - Bits 11 to 2 read as zero and ignore writes.
// - Bit 1 set disables the second two-wire controller.
// - Bit 0 set disables the second converter.
// - A disabled second converter ignores its pin analog settings.
// - Pins shared with a disabled second converter follow only the first converter's analog bit.
// - A cleared analog bit in either enabled converter makes the pin analog.
module pdc3_ctrl
   import pdc3_pkg::*;
#(
   parameter int NPINS = PDC3_NPINS
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic [PDC3_ADDR_W-1:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [NPINS-1:0] cfg1_i,
   input wire logic [NPINS-1:0] cfg2_i,
   output logic [15:0] rdata_o,
   output pdc3_off_t off_o,
   output logic [NPINS-1:0] pin_analog_o
);
   ////////////////////////////////////////////////////////////////////
   logic [15:0] ctrl_ff;
   logic [NPINS-1:0] nxt_analog;
   logic ctrl_hit;

   assign ctrl_hit = (addr_i == PDC3_OFF_CTRL);

   // Unimplemented bits are masked so they never hold state
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctrl_ff <= PDC3_CTRL_RESET;
      end else if (wr_i && ctrl_hit) begin
         ctrl_ff <= wdata_i & PDC3_CTRL_MASK;
      end
   end

   // Unmapped addresses read as zero
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_o <= 16'h0000;
      end else if (rd_i && ctrl_hit) begin
         rdata_o <= ctrl_ff;
      end else begin
         rdata_o <= 16'h0000;
      end
   end

   // Disables come from the register itself, so they follow a write
   always_comb begin
      off_o.timer_nine_off = ctrl_ff[PDC3_BIT_T9];
      off_o.timer_eight_off = ctrl_ff[PDC3_BIT_T8];
      off_o.timer_seven_off = ctrl_ff[PDC3_BIT_T7];
      off_o.timer_six_off = ctrl_ff[PDC3_BIT_T6];
      off_o.second_twowire_off = ctrl_ff[PDC3_BIT_TW2];
      off_o.second_converter_off = ctrl_ff[PDC3_BIT_AD2];
   end

   ////////////////////////////////////////////////////////////////////
   pdc3_pin_mode #(.NPINS(NPINS)) u_pin_mode (
      .cfg1_i(cfg1_i),
      .cfg2_i(cfg2_i),
      .conv2_off_i(ctrl_ff[PDC3_BIT_AD2]),
      .analog_o(nxt_analog)
   );

   // Registered so the pin mode lags the register by one cycle
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pin_analog_o <= '0;
      end else begin
         pin_analog_o <= nxt_analog;
      end
   end

   ////////////////////////////////////////////////////////////////////
   a_write_stores: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (wr_i && ctrl_hit) |=> ctrl_ff == ($past(wdata_i) & PDC3_CTRL_MASK))
      else $error("write not stored");
   a_unimpl_zero: assert property (@(posedge clk_i) disable iff (!resetn_i)
      rdata_o[11:2] == 10'h000)
      else $error("unimplemented bits read nonzero");
   a_read_back: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (rd_i && ctrl_hit && !wr_i) |=> rdata_o == $past(ctrl_ff))
      else $error("read data wrong");
   a_timer_nine: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (wr_i && ctrl_hit) |=> off_o.timer_nine_off == $past(wdata_i[15]))
      else $error("timer nine disable wrong");
   a_timer_eight: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (wr_i && ctrl_hit) |=> off_o.timer_eight_off == $past(wdata_i[14]))
      else $error("timer eight disable wrong");
   a_timer_seven: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (wr_i && ctrl_hit) |=> off_o.timer_seven_off == $past(wdata_i[13]))
      else $error("timer seven disable wrong");
   a_timer_six: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (wr_i && ctrl_hit) |=> off_o.timer_six_off == $past(wdata_i[12]))
      else $error("timer six disable wrong");
   a_twowire_off: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (wr_i && ctrl_hit) |=> off_o.second_twowire_off == $past(wdata_i[1]))
      else $error("two-wire disable wrong");
   a_conv_off: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (wr_i && ctrl_hit) |=> off_o.second_converter_off == $past(wdata_i[0]))
      else $error("converter disable wrong");
   a_pin_digital: assert property (@(posedge clk_i) disable iff (!resetn_i)
      ctrl_ff[0] |=> pin_analog_o == ~$past(cfg1_i))
      else $error("pin mode ignores disabled converter");
   a_pin_analog: assert property (@(posedge clk_i) disable iff (!resetn_i)
      !ctrl_ff[0] |=> pin_analog_o == ~($past(cfg1_i) & $past(cfg2_i)))
      else $error("pin analog mode wrong");
endmodule
`default_nettype wire

// File: verification/test_pdc3_ctrl.sv
// Self-checking bench for the peripheral disable control register 3.
// Assumes the rtl package and pdc3_ctrl are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module test_pdc3_ctrl;
   import pdc3_pkg::*;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [PDC3_ADDR_W-1:0] addr_i = '0;
   logic [15:0] wdata_i = '0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [15:0] cfg1_i = 16'hFFFF;
   logic [15:0] cfg2_i = 16'hFFFF;
   logic [15:0] rdata_o;
   pdc3_off_t off_o;
   logic [15:0] pin_analog_o;
   logic [15:0] rd_val;
   int fails = 0;
   int total_checks = 0;
   int bits[6] = '{15, 14, 13, 12, 1, 0};
   always #2 clk_i = ~clk_i;
   pdc3_ctrl u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .cfg1_i(cfg1_i),
      .cfg2_i(cfg2_i), .rdata_o(rdata_o), .off_o(off_o),
      .pin_analog_o(pin_analog_o));
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] off16();
      return {off_o[5:2], 10'h000, off_o[1:0]};
   endfunction
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // Entered just after an edge; one idle edge follows so no strobe is
   // lowered and raised again in the same time step
   task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
      wr_i <= w;
      rd_i <= !w;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
      rd_i <= 1'b0;
      @(posedge clk_i);
      rd_val = rdata_o;
   endtask
   task automatic tally_and_finish();
      if (fails == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_bits();
      foreach (bits[i]) begin
         bus(1'b1, 4'h0, 16'h0001 << bits[i]);
         bus(1'b0, 4'h0, 16'h0000);
         chk(rd_val, 16'h0001 << bits[i]);
         chk(off16(), 16'h0001 << bits[i]);
         @(posedge clk_i);
         chk(rdata_o, 16'h0000);
      end
   endtask
   task automatic t_unimpl();
      bus(1'b1, 4'h0, 16'hFFFF);
      bus(1'b1, 4'h3, 16'h0000);
      bus(1'b0, 4'h3, 16'h0000);
      chk(rd_val, 16'h0000);
      bus(1'b0, 4'h0, 16'h0000);
      chk(rd_val, 16'hF003);
   endtask
   // Second converter on, then off: its cfg stops mattering
   task automatic t_pins();
      cfg1_i <= 16'hFF00;
      cfg2_i <= 16'h0FF0;
      bus(1'b1, 4'h0, 16'h0000);
      repeat (3) @(posedge clk_i);
      chk(pin_analog_o, ~16'hFF00 | ~16'h0FF0);
      bus(1'b1, 4'h0, 16'h0001);
      repeat (3) @(posedge clk_i);
      chk(pin_analog_o, ~16'hFF00);
   endtask
   task automatic t_midreset();
      bus(1'b1, 4'h0, 16'hF003);
      resetn_i <= 1'b0;
      @(posedge clk_i);
      chk(off16(), 16'h0000);
      resetn_i <= 1'b1;
      @(posedge clk_i);
      bus(1'b0, 4'h0, 16'h0000);
      chk(rd_val, 16'h0000);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // A hang would otherwise leave the run without a verdict
   initial begin
      #100000;
      fails++;
      tally_and_finish();
   end
   initial begin
      repeat (20) @(posedge clk_i);
      chk(off16(), 16'h0000);
      chk(rdata_o, 16'h0000);
      resetn_i <= 1'b1;
      @(posedge clk_i);
      t_bits();
      t_unimpl();
      t_pins();
      t_midreset();
      tally_and_finish();
   end
endmodule
`default_nettype wire
